// >>> frt_regs.sv
// Host registers for floppy tape select, data rate select and drive density.
// Assumes an APB master, pins synchronous to clk, and a command engine that
// loads the precompensation start track.
//
// Summary of operation
// RQ1: Normal mode: tape register holds bits 1:0 only; bits 7:2 undriven on read.
// RQ2: Enhanced mode: media identity pins appear on bits 7:6, untouched by resets.
// RQ3: Bit 7 is media pin 1, inverted when config F1 bit 5 is set.
// RQ4: Bit 6 is media pin 0, inverted when config F1 bit 4 is set; read only.
// RQ5: Bits 5:4 show the F2 bit pair chosen by the selected drive.
// RQ6: Enhanced mode bits 3:2 show boot drive from F1 bits 7:6.
// RQ7: Tape select bits 1:0 read and write alike in both modes.
// RQ8: Rate select register is write only; last rate write of it or CONFIG_CONTROL_REG wins.
// RQ9: Hardware reset loads rate select register with 02h; soft reset keeps it.
// RQ10: Write_shift_code code: 111 none, 001-110 steps of 41.67 or 20.8 ns, 000 default.
// RQ11: Precompensation starts at track 0, changeable by the configure command.
// RQ12: Writing bit 6 of rate select enters manual low power, stopping clocks.
// RQ13: Low power ends on soft reset or data or main status register access.
// RQ14: Bit 7 of rate select resets the controller like DIGITAL_OUTPUT_REG and self clears.
// RQ15: Setting 00 maps codes to 1M, 500, 300, 250; density for 11 and 00.
// RQ16: Setting 01 maps code 01 to 500k; setting 10 maps code 01 to 2M.
// RQ17: Drive type bits pick which rate or density bits drive density pins.
// RQ18: Default write_shift_code is 20.8 ns at 2M, 41.67 ns at 1M, else 125 ns.
// RQ19: DIGITAL_OUTPUT_REG drive select bits are a binary code naming exactly one drive.
// RQ20: DIGITAL_OUTPUT_REG reset bit at 0 holds controller reset until 1 is written.
// RQ21: Media identity bits show live resampled pin levels at each read.
`timescale 1ns/1ps
module frt_regs
  import frt_pkg::*;
#(
  parameter int APB_AW = 12
) (
  // Clock and reset
  input  wire logic              clk,
  input  wire logic              rst,
  // APB slave
  input  wire logic              psel,
  input  wire logic              penable,
  input  wire logic              pwrite,
  input  wire logic [APB_AW-1:0] paddr,
  input  wire logic [31:0]       pwdata,
  output logic                   pready,
  output logic [31:0]            prdata,
  output logic                   pslverr,
  output logic [7:0]             rd_lane_drive,
  // Media identity pins
  input  wire logic [1:0]        media_identity_pins,
  // Configure command load of the precompensation start track
  input  wire logic              cfg_track_we,
  input  wire logic [7:0]        cfg_track_val,
  // Controller and drive side
  output logic                   ctrl_reset,
  output logic                   clk_stop,
  output logic [3:0]             drive_select,
  output frt_rate_type           data_rate,
  output logic [1:0]             rate_output_bits,
  output logic                   density_signal,
  output logic [1:0]             drive_density_outputs,
  output logic [3:0]             write_shift_quanta,
  output logic [7:0]             write_shift_code_track
);

  if (APB_AW < 12) begin : g_bad_aw
    $error("APB_AW must be at least 12 to reach the register indices");
  end
  if (RESET_MIN_CYC >= (1 << SWR_W)) begin : g_bad_swr
    $error("Reset counter too narrow for RESET_MIN_CYC");
  end

  typedef struct packed {
    logic [7:0]   digital_output_reg;
    logic [1:0]   tape_sel;
    logic [7:0]   f1;
    logic [7:0]   f2;
    logic [2:0]   mode;
    logic [7:0]   dsr;
    logic [1:0]   rate_sel;
    logic [7:0]   track;
    logic         lp;
    logic [SWR_W-1:0] swr_cnt;
    logic [1:0]   media;
    logic         pready;
    logic [31:0]  prdata;
    logic         pslverr;
    logic [7:0]   lanes;
    logic         ctrl_reset;
    logic [3:0]   drv_sel;
    frt_rate_type data_rate;
    logic [1:0]   rate_bits;
    logic         density;
    logic [1:0]   ddo;
    logic [3:0]   shift;
  } frt_state_type;

  frt_state_type st_q;
  frt_state_type st_d;

  logic         setup;
  logic         acc;
  logic         lp_set;
  logic         lp_clr;
  logic [1:0]   media_view;
  logic [1:0]   sel_type;
  logic [7:0]   w8;
  logic         hit_any;
  frt_rate_type dec_rate;
  logic [1:0]   dec_bits;
  logic         dec_dens;
  logic [1:0]   dec_ddo;
  logic [3:0]   dec_shift;

  function automatic logic hit(input logic [APB_AW-1:0] a, input logic [9:0] idx);
    hit = (a == APB_AW'({idx, 2'b00}));
  endfunction : hit

  frt_rate_decode u_decode (
    .rate_sel              (st_q.rate_sel),
    .drive_rate_setting    (st_q.mode[MODE_DRT_LSB +: 2]),
    .drive_type            (sel_type),
    .write_shift_code      (st_q.dsr[DSR_PC_LSB +: 3]),
    .data_rate             (dec_rate),
    .rate_output_bits      (dec_bits),
    .density_signal        (dec_dens),
    .drive_density_outputs (dec_ddo),
    .write_shift_quanta    (dec_shift)
  );

  always_comb begin
    st_d   = st_q;
    setup  = psel & ~penable;
    acc    = psel & penable & st_q.pready;
    w8     = pwdata[7:0];
    lp_set = 1'b0;
    lp_clr = 1'b0;
    // The pins are resampled every cycle so a read shows the live level.
    st_d.media = media_identity_pins; // [RQ2] [RQ21]
    media_view = {st_q.media[1] ^ st_q.f1[F1_MID1_INV_BIT], // [RQ3]
                  st_q.media[0] ^ st_q.f1[F1_MID0_INV_BIT]}; // [RQ4]
    sel_type   = st_q.f2[{st_q.digital_output_reg[1:0], 1'b0} +: 2]; // [RQ5]
    hit_any    = hit(paddr, IDX_DOR) | hit(paddr, IDX_TAPE) | hit(paddr, IDX_DSR)
               | hit(paddr, IDX_DATA) | hit(paddr, IDX_CCR) | hit(paddr, IDX_CFG_F1)
               | hit(paddr, IDX_CFG_F2) | hit(paddr, IDX_MODE) | hit(paddr, IDX_TRACK)
               | hit(paddr, IDX_STATUS);

    st_d.dsr[DSR_SWR_BIT] = 1'b0; // [RQ14]
    if (st_q.swr_cnt != '0) begin
      st_d.swr_cnt = st_q.swr_cnt - 1'b1;
    end

    // Read data is latched in the setup cycle and answered one cycle later.
    st_d.pready = setup;
    if (setup) begin
      st_d.prdata  = '0;
      st_d.lanes   = '0;
      st_d.pslverr = ~hit_any;
      if (!pwrite) begin
        if (hit(paddr, IDX_TAPE)) begin
          if (st_q.mode[MODE_ENH_BIT]) begin
            st_d.prdata[7:0] = {media_view, sel_type, // [RQ2] [RQ5]
                                st_q.f1[F1_BOOT_LSB +: 2], st_q.tape_sel}; // [RQ6] [RQ7]
            st_d.lanes = LANES_ALL;
          end else begin
            st_d.prdata[1:0] = st_q.tape_sel; // [RQ1] [RQ7]
            st_d.lanes = LANES_NORMAL; // [RQ1]
          end
        end else if (hit(paddr, IDX_DOR)) begin
          st_d.prdata[7:0] = st_q.digital_output_reg;
          st_d.lanes = LANES_ALL;
        end else if (hit(paddr, IDX_CFG_F1)) begin
          st_d.prdata[7:0] = st_q.f1;
          st_d.lanes = LANES_ALL;
        end else if (hit(paddr, IDX_CFG_F2)) begin
          st_d.prdata[7:0] = st_q.f2;
          st_d.lanes = LANES_ALL;
        end else if (hit(paddr, IDX_MODE)) begin
          st_d.prdata[2:0] = st_q.mode;
          st_d.lanes = LANES_ALL;
        end else if (hit(paddr, IDX_TRACK)) begin
          st_d.prdata[7:0] = st_q.track;
          st_d.lanes = LANES_ALL;
        end else if (hit(paddr, IDX_STATUS)) begin
          st_d.prdata[15:0] = {2'h0, st_q.lp, st_q.ctrl_reset, st_q.data_rate,
                               st_q.shift, st_q.ddo, st_q.density, st_q.rate_bits};
          st_d.lanes = LANES_ALL;
        end
      end
    end

    if (acc && pwrite) begin
      if (hit(paddr, IDX_DOR)) begin
        st_d.digital_output_reg = w8;
      end
      if (hit(paddr, IDX_TAPE)) begin
        st_d.tape_sel = w8[1:0]; // [RQ7]
      end
      if (hit(paddr, IDX_DSR)) begin
        st_d.dsr      = w8;
        st_d.rate_sel = w8[1:0]; // [RQ8]
        lp_set        = w8[DSR_LP_BIT]; // [RQ12]
        if (w8[DSR_SWR_BIT]) begin
          st_d.swr_cnt = SWR_W'(RESET_MIN_CYC); // [RQ14]
        end
      end
      if (hit(paddr, IDX_CCR)) begin
        st_d.rate_sel = w8[1:0]; // [RQ8]
      end
      if (hit(paddr, IDX_CFG_F1)) begin
        st_d.f1 = w8;
      end
      if (hit(paddr, IDX_CFG_F2)) begin
        st_d.f2 = w8;
      end
      if (hit(paddr, IDX_MODE)) begin
        st_d.mode = w8[2:0];
      end
      if (hit(paddr, IDX_TRACK)) begin
        st_d.track = w8;
      end
    end
    if (cfg_track_we) begin
      st_d.track = cfg_track_val; // [RQ11]
    end

    // Reading the status slot at the rate select address is a status access.
    if (acc && (hit(paddr, IDX_DATA) || (hit(paddr, IDX_DSR) && !pwrite))) begin
      lp_clr = 1'b1; // [RQ13]
    end
    if (!st_q.digital_output_reg[DOR_NRESET_BIT] || (st_q.swr_cnt != '0)) begin
      lp_clr = 1'b1; // [RQ13]
    end
    // A new low-power request wins over a clear in the same cycle.
    st_d.lp = lp_set | (st_q.lp & ~lp_clr);

    st_d.ctrl_reset = ~st_d.digital_output_reg[DOR_NRESET_BIT] | (st_d.swr_cnt != '0); // [RQ20] [RQ14]
    st_d.drv_sel    = 4'h1 << st_d.digital_output_reg[1:0]; // [RQ19]
    st_d.data_rate  = dec_rate;
    st_d.rate_bits  = dec_bits;
    st_d.density    = dec_dens;
    st_d.ddo        = dec_ddo;
    st_d.shift      = dec_shift;
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      st_q            <= '0;
      st_q.digital_output_reg        <= DOR_RST;
      st_q.dsr        <= DSR_RST; // [RQ9]
      st_q.rate_sel   <= RATE_RST; // [RQ9]
      st_q.track      <= TRACK_RST; // [RQ11]
      st_q.media      <= media_identity_pins; // [RQ2]
      st_q.ctrl_reset <= 1'b1;
      st_q.drv_sel    <= 4'h1;
      st_q.data_rate  <= RATE_250K;
      st_q.rate_bits  <= RATE_RST;
    end else begin
      st_q <= st_d;
    end
  end

  assign pready                = st_q.pready;
  assign prdata                = st_q.prdata;
  assign pslverr               = st_q.pslverr;
  assign rd_lane_drive         = st_q.lanes;
  assign ctrl_reset            = st_q.ctrl_reset;
  assign clk_stop              = st_q.lp;
  assign drive_select          = st_q.drv_sel;
  assign data_rate             = st_q.data_rate;
  assign rate_output_bits      = st_q.rate_bits;
  assign density_signal        = st_q.density;
  assign drive_density_outputs = st_q.ddo;
  assign write_shift_quanta    = st_q.shift;
  assign write_shift_code_track         = st_q.track;

  normal_tape_read_a: assert property (@(posedge clk) disable iff (rst) // [RQ1]
    (setup && !pwrite && hit(paddr, IDX_TAPE) && !st_q.mode[MODE_ENH_BIT])
      |=> (rd_lane_drive == LANES_NORMAL) && (prdata[7:2] == 6'h00))
    else $error("Normal tape read drove upper bits");

  media_bit7_a: assert property (@(posedge clk) disable iff (rst) // [RQ3]
    (setup && !pwrite && hit(paddr, IDX_TAPE) && st_q.mode[MODE_ENH_BIT])
      |=> prdata[7] == ($past(st_q.media[1]) ^ $past(st_q.f1[F1_MID1_INV_BIT])))
    else $error("Media bit 7 wrong");

  drive_type_id_a: assert property (@(posedge clk) disable iff (rst) // [RQ5]
    (setup && !pwrite && hit(paddr, IDX_TAPE) && st_q.mode[MODE_ENH_BIT])
      |=> prdata[5:4] == $past(st_q.f2[{st_q.digital_output_reg[1:0], 1'b0} +: 2]))
    else $error("Drive type id wrong");

  rate_hw_reset_a: assert property (@(posedge clk) // [RQ9]
    rst |=> (st_q.dsr == DSR_RST) && (st_q.rate_sel == RATE_RST))
    else $error("Rate select register not 02h after reset");

  rate_ccr_wins_a: assert property (@(posedge clk) disable iff (rst) // [RQ8]
    (acc && pwrite && hit(paddr, IDX_CCR)) |=> st_q.rate_sel == $past(pwdata[1:0]))
    else $error("Last rate write did not take effect");

  low_power_enter_a: assert property (@(posedge clk) disable iff (rst) // [RQ12]
    (acc && pwrite && hit(paddr, IDX_DSR) && pwdata[DSR_LP_BIT]) |=> clk_stop)
    else $error("Low power not entered");

  low_power_exit_a: assert property (@(posedge clk) disable iff (rst) // [RQ13]
    (clk_stop && acc && hit(paddr, IDX_DATA)) |=> !clk_stop)
    else $error("Low power not left on data access");

  soft_reset_pulse_a: assert property (@(posedge clk) disable iff (rst) // [RQ14]
    (acc && pwrite && hit(paddr, IDX_DSR) && pwdata[DSR_SWR_BIT])
      |=> ctrl_reset [*5] ##1 !st_q.dsr[DSR_SWR_BIT])
    else $error("Self-clearing reset too short");

  dor_reset_hold_a: assert property (@(posedge clk) disable iff (rst) // [RQ20]
    ($rose(st_q.digital_output_reg[DOR_NRESET_BIT]) && st_q.swr_cnt == '0) |-> !ctrl_reset)
    else $error("Controller reset not released");

  density_map_a: assert property (@(posedge clk) disable iff (rst) // [RQ17]
    ($past(sel_type) == 2'b11) |-> drive_density_outputs == rate_output_bits)
    else $error("Drive density map wrong for type 11");

  density_sig_a: assert property (@(posedge clk) disable iff (rst) // [RQ15]
    density_signal == (rate_output_bits == 2'b11 || rate_output_bits == 2'b00))
    else $error("Density signal wrong");

endmodule : frt_regs

// >>> frt_pkg.sv
// Shared constants and types for the floppy rate and tape register block.
// Assumes a 50 MHz clock and an APB slave with 32-bit data and byte addresses.
package frt_pkg;

  // Register indices; the byte address is four times the index.
  localparam logic [9:0] IDX_DOR      = 10'h3f2;
  localparam logic [9:0] IDX_TAPE     = 10'h3f3;
  localparam logic [9:0] IDX_DSR      = 10'h3f4;
  localparam logic [9:0] IDX_DATA     = 10'h3f5;
  localparam logic [9:0] IDX_CCR      = 10'h3f7;
  localparam logic [9:0] IDX_CFG_F1   = 10'h040;
  localparam logic [9:0] IDX_CFG_F2   = 10'h041;
  localparam logic [9:0] IDX_MODE     = 10'h042;
  localparam logic [9:0] IDX_TRACK    = 10'h043;
  localparam logic [9:0] IDX_STATUS   = 10'h044;

  // Field positions.
  localparam int DOR_NRESET_BIT   = 2;
  localparam int DSR_LP_BIT       = 6;
  localparam int DSR_SWR_BIT      = 7;
  localparam int DSR_PC_LSB       = 2;
  localparam int MODE_ENH_BIT     = 0;
  localparam int MODE_DRT_LSB     = 1;
  localparam int F1_MID1_INV_BIT  = 5;
  localparam int F1_MID0_INV_BIT  = 4;
  localparam int F1_BOOT_LSB      = 6;

  // Values after hardware reset.
  localparam logic [7:0] DOR_RST   = 8'h00;
  localparam logic [7:0] DSR_RST   = 8'h02;
  localparam logic [1:0] RATE_RST  = 2'h2;
  localparam logic [7:0] TRACK_RST = 8'h00;

  // Lane masks for reads of the tape register.
  localparam logic [7:0] LANES_NORMAL = 8'h03;
  localparam logic [7:0] LANES_ALL    = 8'hff;

  // Precompensation codes.
  localparam logic [2:0] PC_DEFAULT = 3'h0;
  localparam logic [2:0] PC_NONE    = 3'h7;

  // Timing: least controller reset time from the self-clearing reset bit.
  localparam int CLK_MHZ       = 50;
  localparam int RESET_MIN_NS  = 100;
  localparam int RESET_MIN_CYC = (RESET_MIN_NS * CLK_MHZ + 999) / 1000;
  localparam int SWR_W         = 3;

  typedef enum logic [2:0] {
    RATE_250K,
    RATE_300K,
    RATE_500K,
    RATE_1M,
    RATE_2M
  } frt_rate_type;

endpackage : frt_pkg

// >>> frt_rate_decode.sv
// Decode of rate select, drive rate setting and drive type onto drive pins.
// Assumes purely combinational use; the caller registers every result.
`timescale 1ns/1ps
module frt_rate_decode
  import frt_pkg::*;
(
  // Settings
  input  wire logic [1:0]   rate_sel,
  input  wire logic [1:0]   drive_rate_setting,
  input  wire logic [1:0]   drive_type,
  input  wire logic [2:0]   write_shift_code,
  // Results
  output frt_rate_type      data_rate,
  output logic [1:0]        rate_output_bits,
  output logic              density_signal,
  output logic [1:0]        drive_density_outputs,
  output logic [3:0]        write_shift_quanta
);

  always_comb begin
    case (rate_sel) // [RQ15] [RQ16]
      2'b11: data_rate = RATE_1M;
      2'b00: data_rate = RATE_500K;
      2'b01: begin
        if (drive_rate_setting == 2'b01) begin
          data_rate = RATE_500K;
        end else if (drive_rate_setting == 2'b10) begin
          data_rate = RATE_2M;
        end else begin
          data_rate = RATE_300K;
        end
      end
      default: data_rate = RATE_250K;
    endcase
    rate_output_bits = rate_sel; // [RQ15]
    density_signal   = (rate_sel == 2'b11) || (rate_sel == 2'b00); // [RQ15]
    case (drive_type) // [RQ17]
      2'b00:   drive_density_outputs = {rate_sel[0], density_signal};
      2'b10:   drive_density_outputs = {rate_sel[0], rate_sel[1]};
      2'b01:   drive_density_outputs = {rate_sel[0], ~density_signal};
      default: drive_density_outputs = {rate_sel[1], rate_sel[0]};
    endcase
    // Shift is counted in quanta of about 20.8 ns, half the slow-rate step.
    if (write_shift_code == PC_NONE) begin // [RQ10]
      write_shift_quanta = 4'h0;
    end else if (write_shift_code == PC_DEFAULT) begin // [RQ18]
      if (data_rate == RATE_2M) begin
        write_shift_quanta = 4'h1;
      end else if (data_rate == RATE_1M) begin
        write_shift_quanta = 4'h2;
      end else begin
        write_shift_quanta = 4'h6;
      end
    end else if (data_rate == RATE_2M) begin // [RQ10]
      write_shift_quanta = {1'b0, write_shift_code};
    end else begin
      write_shift_quanta = {write_shift_code, 1'b0};
    end
  end

endmodule : frt_rate_decode

// >>> frt_host.sv
// Bus master model standing in for the host processor on the APB port.
// Assumes one clock; the bench calls xfer through the instance name.
`timescale 1ns/1ps
module frt_host (
  // Clock
  input  wire logic        clk,
  // APB master side
  output logic             psel,
  output logic             penable,
  output logic             pwrite,
  output logic [11:0]      paddr,
  output logic [31:0]      pwdata,
  input  wire logic        pready,
  input  wire logic [31:0] prdata,
  input  wire logic        pslverr,
  input  wire logic [7:0]  rd_lane_drive
);
  initial begin
    psel    = 1'b0;
    penable = 1'b0;
    pwrite  = 1'b0;
    paddr   = 12'h000;
    pwdata  = 32'h0;
  end

  // The request stays put until pready is seen high at a rising edge or 20 edges pass, so an
  // answer within that limit never catches a half-changed address or data word.
  task automatic xfer(input logic w, input logic [11:0] a, input logic [7:0] d,
                      output logic [7:0] rd, output logic [7:0] ln, output logic err);
    int n;
    n = 0;
    @(posedge clk);
    psel    <= 1'b1;
    penable <= 1'b0;
    pwrite  <= w;
    paddr   <= a;
    pwdata  <= {24'h0, d};
    @(posedge clk);
    penable <= 1'b1;
    do begin
      @(posedge clk);
      n++;
    end while (pready !== 1'b1 && n < 20);
    rd      = prdata[7:0];
    ln      = rd_lane_drive;
    err     = (n < 20) ? pslverr : 1'bx;
    psel    <= 1'b0;
    penable <= 1'b0;
  endtask : xfer
endmodule : frt_host

// >>> tb.sv
// Self-checking bench for the floppy rate and tape register block.
// Assumes frt_pkg is compiled first and the host model drives the APB port.
`timescale 1ns/1ps
module tb
  import frt_pkg::*;
;
  logic clk = 1'b0;
  logic rst = 1'b1;
  logic psel, penable, pwrite, pready, pslverr;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata;
  logic [7:0] rd_lane_drive, write_shift_code_track;
  logic [1:0] media_identity_pins = 2'h0;
  logic cfg_track_we = 1'b0;
  logic [7:0] cfg_track_val = 8'h00;
  logic ctrl_reset, clk_stop, density_signal;
  logic [3:0] drive_select, write_shift_quanta;
  frt_rate_type data_rate;
  logic [1:0] rate_output_bits, drive_density_outputs;
  int fail_count = 0;
  int checks_done = 0;
  logic [7:0] digital_output_reg, f1, f2, mode, d, r, l;
  logic [1:0] tsel, rsel;
  logic [2:0] pc;
  logic e;
  int n;

  always #10 clk = ~clk;

  frt_regs #(.APB_AW(12)) i_frt_regs (
    .clk(clk), .rst(rst), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rd_lane_drive(rd_lane_drive), .media_identity_pins(media_identity_pins),
    .cfg_track_we(cfg_track_we), .cfg_track_val(cfg_track_val), .ctrl_reset(ctrl_reset),
    .clk_stop(clk_stop), .drive_select(drive_select), .data_rate(data_rate),
    .rate_output_bits(rate_output_bits), .density_signal(density_signal),
    .drive_density_outputs(drive_density_outputs),
    .write_shift_quanta(write_shift_quanta), .write_shift_code_track(write_shift_code_track));

  frt_host i_frt_host (
    .clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite), .paddr(paddr),
    .pwdata(pwdata), .pready(pready), .prdata(prdata), .pslverr(pslverr),
    .rd_lane_drive(rd_lane_drive));

  function automatic frt_rate_type exp_rate(input logic [1:0] s, input logic [1:0] t);
    case (s)
      2'b11: return RATE_1M;
      2'b00: return RATE_500K;
      2'b10: return RATE_250K;
      default: return (t == 2'b01) ? RATE_500K : (t == 2'b10) ? RATE_2M : RATE_300K;
    endcase
  endfunction : exp_rate

  function automatic logic [1:0] exp_ddo(input logic [1:0] s, input logic [1:0] dt);
    logic den;
    den = (s[1] == s[0]);
    case (dt)
      2'b00: return {s[0], den};
      2'b10: return {s[0], s[1]};
      2'b01: return {s[0], ~den};
      default: return {s[1], s[0]};
    endcase
  endfunction : exp_ddo

  // Shift in units of 20.83 ns: one unit per step at 2 Mbps, two below it.
  function automatic logic [3:0] exp_shift(input logic [2:0] p, input frt_rate_type t);
    if (p == PC_NONE) return 4'h0;
    if (p == PC_DEFAULT) return (t == RATE_2M) ? 4'h1 : (t == RATE_1M) ? 4'h2 : 4'h6;
    return (t == RATE_2M) ? {1'b0, p} : {p, 1'b0};
  endfunction : exp_shift

  task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      fail_count++;
      $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
    end
  endtask : check

  task automatic wr(input logic [11:0] a, input logic [7:0] v);
    i_frt_host.xfer(1'b1, a, v, r, l, e);
    check("write error", 32'(e), 32'h0);
  endtask : wr

  task automatic chk_out;
    frt_rate_type t;
    repeat (3) @(posedge clk);
    #1;
    t = exp_rate(rsel, mode[2:1]);
    check("rate", 32'(data_rate), 32'(t));
    check("rate bits", 32'(rate_output_bits), 32'(rsel));
    check("density", 32'(density_signal), 32'(rsel[1] == rsel[0]));
    check("drive density", 32'(drive_density_outputs),
          32'(exp_ddo(rsel, f2[2*digital_output_reg[1:0] +: 2])));
    check("shift", 32'(write_shift_quanta), 32'(exp_shift(pc, t)));
    check("drive select", 32'(drive_select), 32'h1 << digital_output_reg[1:0]);
  endtask : chk_out

  task automatic chk_tape;
    logic [7:0] x;
    @(posedge clk);
    media_identity_pins <= 2'($urandom);
    repeat (2) @(posedge clk);
    x = mode[0] ? {media_identity_pins[1] ^ f1[5], media_identity_pins[0] ^ f1[4],
                   f2[2*digital_output_reg[1:0] +: 2], f1[7:6], tsel} : {6'h00, tsel};
    i_frt_host.xfer(1'b0, 12'hfcc, 8'h00, r, l, e);
    check("tape data", 32'(r), 32'(x));
    check("tape lanes", 32'(l), mode[0] ? 32'hff : 32'h03);
  endtask : chk_tape

  task automatic print_verdict;
    $display("Checks made %0d, mismatches %0d", checks_done, fail_count);
    if (fail_count == 0 && checks_done > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask : print_verdict

  task automatic hw_reset;
    @(posedge clk);
    rst <= 1'b1;
    repeat (8) @(posedge clk);
    rst <= 1'b0;
    {digital_output_reg, f1, f2, mode, tsel, rsel, pc} = {32'h0, 2'h0, RATE_RST, PC_DEFAULT};
    chk_out;
    check("reset held", 32'(ctrl_reset), 32'h1);
    check("start track", 32'(write_shift_code_track), 32'h0);
    check("low power", 32'(clk_stop), 32'h0);
  endtask : hw_reset

  initial begin
    #1_000_000;
    fail_count++;
    print_verdict;
  end

  initial begin
    void'($urandom(32'h01eb));
    hw_reset;
    chk_tape;
    i_frt_host.xfer(1'b0, 12'hfd0, 8'h00, r, l, e);
    check("rate reg read", 32'({l, r}), 32'h0);
    for (int k = 0; k < 3; k++) begin
      digital_output_reg = k[0] ? 8'h00 : 8'h04;
      wr(12'hfc8, digital_output_reg);
      repeat (8) @(posedge clk);
      #1;
      check("dor reset", 32'(ctrl_reset), {31'h0, ~digital_output_reg[2]});
    end
    for (int i = 0; i < 48; i++) begin
      digital_output_reg = {5'h00, 1'b1, 2'($urandom)};
      wr(12'hfc8, digital_output_reg);
      f1 = 8'($urandom);
      wr(12'h100, f1);
      f2 = 8'($urandom);
      wr(12'h104, f2);
      mode = {5'h00, 2'($urandom_range(2, 0)), 1'($urandom)};
      wr(12'h108, mode);
      d = 8'($urandom);
      wr(12'hfcc, d);
      tsel = d[1:0];
      rsel = 2'($urandom);
      if (i[0]) begin
        pc = i[3:1];
        wr(12'hfd0, {3'b000, pc, rsel});
      end else begin
        wr(12'hfdc, {6'h00, rsel});
      end
      chk_out;
      chk_tape;
    end
    pc = 3'h3;
    rsel = 2'b01;
    wr(12'hfd0, {3'b100, pc, rsel});
    n = 0;
    for (int k = 0; k < 20; k++) begin
      #1;
      if (ctrl_reset === 1'b1) n++;
      @(posedge clk);
    end
    check("soft reset length", 32'(n), 32'(RESET_MIN_CYC));
    chk_out;
    for (int k = 0; k < 3; k++) begin
      wr(12'hfd0, {3'b010, pc, rsel});
      repeat (2) @(posedge clk);
      #1;
      check("low power on", 32'(clk_stop), 32'h1);
      if (k == 2) wr(12'hfd0, {3'b100, pc, rsel});
      else i_frt_host.xfer(1'b0, k[0] ? 12'hfd4 : 12'hfd0, 8'h00, r, l, e);
      repeat (8) @(posedge clk);
      #1;
      check("low power off", 32'(clk_stop), 32'h0);
    end
    i_frt_host.xfer(1'b0, 12'h200, 8'h00, r, l, e);
    check("unmapped error", 32'({e, r}), 32'h100);
    i_frt_host.xfer(1'b1, 12'hfcd, 8'h5a, r, l, e);
    check("unaligned error", 32'(e), 32'h1);
    @(posedge clk);
    cfg_track_we  <= 1'b1;
    cfg_track_val <= 8'h27;
    @(posedge clk);
    cfg_track_we <= 1'b0;
    repeat (2) @(posedge clk);
    #1;
    check("start track", 32'(write_shift_code_track), 32'h27);
    hw_reset;
    mode = 8'h01;
    wr(12'h108, mode);
    chk_tape;
    print_verdict;
  end
endmodule : tb
